// ==== logic/qdc_regs_map.vh ====
// register offsets, field positions and reset values of the shared control bank
`ifndef QDC_REGS_MAP_VH
`define QDC_REGS_MAP_VH
`define QDC_ADDR_CODE0 8'h19
`define QDC_ADDR_CODE1 8'h1a
`define QDC_ADDR_CODE2 8'h1b
`define QDC_ADDR_CODE3 8'h1c
`define QDC_ADDR_CONFIG 8'h1f
`define QDC_ADDR_TRIGGER 8'h20
`define QDC_PM_PAGE_SHARED 8'hff
`define QDC_PM_REG_CODE 8'h21
`define QDC_PM_REG_CONFIG 8'he3
`define QDC_PM_REG_TRIGGER 8'he4
`define QDC_CONFIG_RESET 16'h0fff
`define QDC_CODE_RESET 16'h0000
`define QDC_CODE_MASK 16'hfff0
`define QDC_CODE_MID 16'h8000
`define QDC_CFG_HOLD 15
`define QDC_CFG_FREEZE 14
`define QDC_CFG_ROW 13
`define QDC_CFG_REF 12
`define QDC_KEY_HI 15
`define QDC_KEY_LO 12
`define QDC_KEY_VALUE 4'h5
`define QDC_SWRST_HI 11
`define QDC_SWRST_LO 8
`define QDC_SWRST_VALUE 4'ha
`define QDC_TRG_LOAD 7
`define QDC_TRG_CLEAR 6
`define QDC_TRG_DUMP 4
`define QDC_TRG_PROTECT 3
`define QDC_TRG_ROW 2
`define QDC_TRG_STORE 1
`define QDC_TRG_RESTORE 0
`define QDC_PD_STRIDE 3
`define QDC_VPD_LSB 1
`define QDC_IPD_LSB 0
`endif

// ==== logic/qdc_code_mem.v ====
// four-word channel code store with registered read data
`include "qdc_regs_map.vh"
module qdc_code_mem #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // write side
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire clr_all,
  input wire [DEPTH-1:0] clr_mid,
  // read side
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  integer i;

  ////////////////////////////////////////////////////////////////////////
  // storage; a clear overrides a same-cycle write
  always @(posedge clk)
  begin
    for (i = 0; i < DEPTH; i = i + 1)
    begin
      if (!rstn)
        mem_r[i] <= `QDC_CODE_RESET;
      else if (clr_all)
        mem_r[i] <= clr_mid[i] ? `QDC_CODE_MID : `QDC_CODE_RESET;
      else if (wr_en && (wr_addr == i[AW-1:0]))
        mem_r[i] <= wr_data & `QDC_CODE_MASK;
    end
  end

  // registered read port
  always @(posedge clk)
  begin
    if (!rstn)
      rd_data <= `QDC_CODE_RESET;
    else
      rd_data <= mem_r[rd_addr];
  end
endmodule

// ==== logic/qdc_regs.v ====
// shared configuration, trigger and channel code registers of a quad converter
// Summary of operation
// RULE1 - codes left-aligned bits 15-4, low nibble ignored
// RULE2 - shorter resolutions use upper bits only
// RULE3 - codes at 19h-1Ch, paged register 21h
// RULE4 - config 1Fh/E3h, trigger 20h/E4h on page FFh
// RULE5 - config bit 15 selects latching comparator
// RULE6 - config bit 14 freezes all registers
// RULE7 - key 0101 in bits 15-12 unlocks
// RULE8 - host writes key, then clears freeze bit
// RULE9 - config bit 13 selects dump row
// RULE10 - config bit 12 enables internal reference
// RULE11 - voltage powerdown two-bit fields, reset 11
// RULE12 - current powerdown bits 9,6,3,0, reset 1
// RULE13 - 1010 in bits 11-8 resets everything
// RULE14 - bit 7 loads selected channel outputs
// RULE15 - bit 6 clears codes to zero/mid
// RULE16 - bits 4,3 start dump and protect
// RULE17 - bit 2 reads one memory row
// RULE18 - bits 1,0 store and restore memory
// RULE19 - frozen writes dropped silently, key allowed
`include "qdc_regs_map.vh"
module qdc_regs #(
  parameter DW = 16,
  parameter CH = 4
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // register access from the serial front end
  input wire wr_en,
  input wire rd_en,
  input wire pm_mode,
  input wire [7:0] pm_page,
  input wire [7:0] addr,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata,
  output reg rvalid,
  // per-channel selects from the function configuration
  input wire [CH-1:0] sync_select,
  input wire [CH-1:0] clear_level_select,
  // configuration outputs
  output reg window_hold_select,
  output reg register_freeze,
  output reg dump_row_select,
  output reg internal_ref_en,
  output reg [2*CH-1:0] voltage_out_powerdown,
  output reg [CH-1:0] current_out_powerdown,
  // one-cycle command pulses
  output reg [CH-1:0] load_outputs_strobe,
  output reg clear_outputs_strobe,
  output reg fault_dump_strobe,
  output reg protect_strobe,
  output reg snapshot_row_read,
  output reg nonvolatile_store_strobe,
  output reg nonvolatile_restore_strobe,
  output reg soft_reset_pulse
);
  reg [DW-1:0] config_r;
  reg [3:0] key_r;
  reg key_ok_r;
  reg soft_rst_r;
  wire srst_n;
  wire [DW-1:0] code_rd;
  reg [1:0] rd_kind_r;
  // read pending, one edge behind the request, so rvalid meets the data
  reg rd_pend_r;

  // decoded targets
  reg hit_code;
  reg hit_cfg;
  reg hit_trg;
  reg [1:0] code_idx;

  ////////////////////////////////////////////////////////////////////////
  // software reset key in the trigger word; shared by the reset and its pulse
  function swrst_key;
    input [DW-1:0] word;
    begin
      swrst_key = (word[`QDC_SWRST_HI:`QDC_SWRST_LO] == `QDC_SWRST_VALUE);
    end
  endfunction

  // voltage powerdown fields, channel n at bits 3n+2:3n+1 of the config word
  function [2*CH-1:0] vpd_of;
    input [DW-1:0] word;
    integer n;
    begin
      vpd_of = {2*CH{1'b0}};
      for (n = 0; n < CH; n = n + 1)
      begin
        vpd_of[2*n] = word[`QDC_PD_STRIDE*n+`QDC_VPD_LSB];
        vpd_of[2*n+1] = word[`QDC_PD_STRIDE*n+`QDC_VPD_LSB+1];
      end
    end
  endfunction

  // current powerdown bits, channel n at bit 3n; reset value comes through here too
  function [CH-1:0] ipd_of;
    input [DW-1:0] word;
    integer n;
    begin
      ipd_of = {CH{1'b0}};
      for (n = 0; n < CH; n = n + 1)
        ipd_of[n] = word[`QDC_PD_STRIDE*n+`QDC_IPD_LSB];
    end
  endfunction

  // both addressing forms resolve to one target [RULE3] [RULE4]
  always @*
  begin
    hit_code = 1'b0;
    hit_cfg = 1'b0;
    hit_trg = 1'b0;
    code_idx = 2'b00;
    if (pm_mode)
    begin
      if (pm_page < CH && addr == `QDC_PM_REG_CODE)
      begin
        hit_code = 1'b1;
        code_idx = pm_page[1:0];
      end
      hit_cfg = (pm_page == `QDC_PM_PAGE_SHARED) && (addr == `QDC_PM_REG_CONFIG);
      hit_trg = (pm_page == `QDC_PM_PAGE_SHARED) && (addr == `QDC_PM_REG_TRIGGER);
    end
    else
    begin
      if (addr >= `QDC_ADDR_CODE0 && addr <= `QDC_ADDR_CODE3)
      begin
        hit_code = 1'b1;
        // flat codes sit at 19h-1Ch; subtracting one maps 19h onto slot 0
        code_idx = addr[1:0] - 2'b01;
      end
      hit_cfg = (addr == `QDC_ADDR_CONFIG);
      hit_trg = (addr == `QDC_ADDR_TRIGGER);
    end
  end

  // software reset acts like power-on for the whole bank [RULE13]
  // taken from a flop, so it is glitch-free and lasts one full cycle
  assign srst_n = rstn & ~soft_rst_r;

  wire key_hit = wr_en && hit_trg && (wdata[`QDC_KEY_HI:`QDC_KEY_LO] == `QDC_KEY_VALUE); // [RULE7]
  // frozen bank drops writes quietly, no error flag exists [RULE6] [RULE19]
  wire wr_open = wr_en && !config_r[`QDC_CFG_FREEZE];
  // unlocking needs a prior key, then a config write with freeze low [RULE8] [RULE19]
  wire unfreeze = wr_en && hit_cfg && config_r[`QDC_CFG_FREEZE] && key_ok_r
    && !wdata[`QDC_CFG_FREEZE];
  wire trg_go = wr_open && hit_trg;

  ////////////////////////////////////////////////////////////////////////
  // code storage; low nibble masked, narrow parts use upper bits [RULE1] [RULE2]
  // the clear goes through the store itself so stored code and output agree
  qdc_code_mem #(
    .WIDTH(DW),
    .DEPTH(CH),
    .AW(2)
  ) u_mem (
    .clk(clk),
    .rstn(srst_n),
    .wr_en(wr_open && hit_code),
    .wr_addr(code_idx),
    .wr_data(wdata),
    .clr_all(trg_go && wdata[`QDC_TRG_CLEAR]), // [RULE15]
    .clr_mid(clear_level_select),
    .rd_addr(code_idx),
    .rd_data(code_rd)
  );

  ////////////////////////////////////////////////////////////////////////
  // configuration register and unlock key
  always @(posedge clk)
  begin
    if (!srst_n)
    begin
      config_r <= `QDC_CONFIG_RESET; // [RULE11] [RULE12]
      key_r <= 4'h0;
      key_ok_r <= 1'b0;
    end
    else
    begin
      // a plain write needs an open bank; the unlock path touches freeze only
      if (wr_open && hit_cfg)
        config_r <= wdata;
      else if (unfreeze)
        config_r[`QDC_CFG_FREEZE] <= 1'b0;
      // key is taken even while frozen; consumed by the unlock
      if (key_hit)
      begin
        key_r <= `QDC_KEY_VALUE;
        key_ok_r <= 1'b1;
      end
      else if (wr_en && hit_trg)
      begin
        key_r <= wdata[`QDC_KEY_HI:`QDC_KEY_LO];
        key_ok_r <= 1'b0;
      end
      else if (unfreeze)
        key_ok_r <= 1'b0;
    end
  end

  // self-clearing soft reset, held one cycle then released
  always @(posedge clk)
  begin
    if (!rstn || soft_rst_r)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= trg_go && swrst_key(wdata); // [RULE13]
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration outputs mirror the register
  always @(posedge clk)
  begin
    if (!srst_n)
    begin
      window_hold_select <= 1'b0;
      register_freeze <= 1'b0;
      dump_row_select <= 1'b0;
      internal_ref_en <= 1'b0;
      voltage_out_powerdown <= vpd_of(`QDC_CONFIG_RESET); // [RULE11]
      current_out_powerdown <= ipd_of(`QDC_CONFIG_RESET); // [RULE12]
    end
    else
    begin
      window_hold_select <= config_r[`QDC_CFG_HOLD]; // [RULE5]
      register_freeze <= config_r[`QDC_CFG_FREEZE]; // [RULE6]
      dump_row_select <= config_r[`QDC_CFG_ROW]; // [RULE9]
      internal_ref_en <= config_r[`QDC_CFG_REF]; // [RULE10]
      // channel n field at 3n+2:3n+1, current bit at 3n [RULE11] [RULE12]
      voltage_out_powerdown <= vpd_of(config_r);
      current_out_powerdown <= ipd_of(config_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command strobes; trigger command bits never store, so bits 11-0 read back zero and bits 15-12 return the key
  // a frozen bank raises none of them, since trg_go already carries the freeze
  always @(posedge clk)
  begin
    if (!srst_n)
    begin
      load_outputs_strobe <= {CH{1'b0}};
      clear_outputs_strobe <= 1'b0;
      fault_dump_strobe <= 1'b0;
      protect_strobe <= 1'b0;
      snapshot_row_read <= 1'b0;
      nonvolatile_store_strobe <= 1'b0;
      nonvolatile_restore_strobe <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end
    else
    begin
      load_outputs_strobe <= {CH{trg_go && wdata[`QDC_TRG_LOAD]}} & sync_select; // [RULE14]
      clear_outputs_strobe <= trg_go && wdata[`QDC_TRG_CLEAR]; // [RULE15]
      fault_dump_strobe <= trg_go && wdata[`QDC_TRG_DUMP]; // [RULE16]
      protect_strobe <= trg_go && wdata[`QDC_TRG_PROTECT]; // [RULE16]
      snapshot_row_read <= trg_go && wdata[`QDC_TRG_ROW]; // [RULE17]
      nonvolatile_store_strobe <= trg_go && wdata[`QDC_TRG_STORE]; // [RULE18]
      nonvolatile_restore_strobe <= trg_go && wdata[`QDC_TRG_RESTORE]; // [RULE18]
      soft_reset_pulse <= trg_go && swrst_key(wdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path: one cycle to match the registered memory port
  always @(posedge clk)
  begin
    if (!srst_n)
      rd_kind_r <= 2'b00;
    else if (rd_en)
      rd_kind_r <= hit_code ? 2'b01 : (hit_cfg ? 2'b10 : (hit_trg ? 2'b11 : 2'b00));
    else
      rd_kind_r <= 2'b00;
  end

  // data and rvalid two edges after the strobe; unmapped reads return zero
  always @(posedge clk)
  begin
    if (!srst_n)
    begin
      rd_pend_r <= 1'b0;
      rvalid <= 1'b0;
      rdata <= {DW{1'b0}};
    end
    else
    begin
      rd_pend_r <= rd_en;
      rvalid <= rd_pend_r;
      // rdata holds between reads so a slow host may still fetch it
      if (rd_pend_r)
      begin
        case (rd_kind_r)
          2'b01: rdata <= code_rd;
          2'b10: rdata <= config_r;
          2'b11: rdata <= {key_r, 12'h000};
          default: rdata <= {DW{1'b0}};
        endcase
      end
    end
  end
endmodule

// ==== test/qdc_regs_asserts.sv ====
// port-level assertions for the shared control bank
module qdc_regs_chk (
  // clock and reset
  input wire clk,
  input wire rstn,
  // requests
  input wire wr_en,
  input wire rd_en,
  input wire pm_mode,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire rvalid,
  input wire [3:0] sync_select,
  // outputs under watch
  input wire register_freeze,
  input wire [7:0] voltage_out_powerdown,
  input wire [3:0] current_out_powerdown,
  input wire [3:0] load_outputs_strobe,
  input wire clear_outputs_strobe,
  input wire fault_dump_strobe,
  input wire protect_strobe,
  input wire snapshot_row_read,
  input wire nonvolatile_store_strobe,
  input wire nonvolatile_restore_strobe,
  input wire soft_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // flat-map decodes; freeze is taken from register_freeze at the write, one cycle behind the bank's own bit
  wire wcfg = wr_en && !pm_mode && addr == 8'h1f;
  wire wtrg = wr_en && !pm_mode && addr == 8'h20 && !register_freeze;
  wire [10:0] stb = {soft_reset_pulse, load_outputs_strobe, clear_outputs_strobe,
    fault_dump_strobe, protect_strobe, snapshot_row_read, nonvolatile_store_strobe,
    nonvolatile_restore_strobe};
  ////////////////////////////////////////
  a_read_answer: assert property (rd_en |-> ##2 rvalid) else $error("read unanswered");
  a_cfg_fields:
  assert property ($past(wcfg && !register_freeze, 2) |-> register_freeze == $past(wdata[14], 2)
    && voltage_out_powerdown == $past({wdata[11:10], wdata[8:7], wdata[5:4], wdata[2:1]}, 2)
    && current_out_powerdown == $past({wdata[9], wdata[6], wdata[3], wdata[0]}, 2))
    else $error("config outputs wrong");
  a_freeze_hold:
  assert property (wcfg && register_freeze && wdata[14] |=> $stable(voltage_out_powerdown) [*2])
    else $error("frozen config changed");
  a_load_mask:
  assert property (wtrg && wdata[7] |-> ##[1:2] load_outputs_strobe == sync_select)
    else $error("load strobe wrong");
  a_clear_cmd:
  assert property (wtrg && wdata[6] |-> ##[1:2] clear_outputs_strobe) else $error("no clear");
  a_soft_reset:
  assert property (wtrg && wdata[11:8] == 4'ha |-> ##[1:2] soft_reset_pulse)
    else $error("no soft reset");
  a_strobe_cause:
  assert property (stb != 0 |-> $past(wtrg) || $past(wtrg, 2)) else $error("stray strobe");
  a_strobe_width:
  assert property (stb != 0 |=> (stb & $past(stb)) == 0) else $error("strobe too long");
endmodule
bind qdc_regs qdc_regs_chk u_qdc_regs_chk (.clk, .rstn, .wr_en, .rd_en, .pm_mode, .addr,
  .wdata, .rvalid, .sync_select, .register_freeze, .voltage_out_powerdown,
  .current_out_powerdown, .load_outputs_strobe, .clear_outputs_strobe, .fault_dump_strobe,
  .protect_strobe, .snapshot_row_read, .nonvolatile_store_strobe,
  .nonvolatile_restore_strobe, .soft_reset_pulse);

// ==== test/qdc_host.sv ====
// host model issuing register writes and reads
module qdc_host (
  // clock
  input wire logic clk,
  // request side
  output logic wr_en,
  output logic rd_en,
  output logic pm_mode,
  output logic [7:0] pm_page,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  // answer side
  input wire logic rvalid,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle lines at time zero
  initial
  begin
    {wr_en, rd_en, pm_mode, pm_page, addr, wdata} = '0;
  end
  // released lines show inverted values; idle gap lets freeze settle first
  task automatic put(input logic w, pm, input logic [7:0] pg, a, input logic [15:0] d);
    @(posedge clk);
    {wr_en, rd_en, pm_mode, pm_page, addr, wdata} <= {w, !w, pm, pg, a, d};
    @(posedge clk);
    {wr_en, rd_en, addr, wdata} <= {2'b00, ~a, ~d};
    repeat (2) @(posedge clk);
  endtask
  // answer stands after the first edge past the taking edge; caught settled
  task automatic get(input logic pm, input logic [7:0] pg, a, output logic [15:0] d);
    @(posedge clk);
    {wr_en, rd_en, pm_mode, pm_page, addr, wdata} <= {2'b01, pm, pg, a, 16'hffff};
    @(posedge clk);
    {rd_en, addr} <= {1'b0, ~a};
    @(posedge clk);
    @(negedge clk);
    d = (rvalid === 1'b1) ? rdata : 16'hxxxx;
    @(posedge clk);
  endtask
  // key first, then freeze bit cleared
  task automatic unlock(input logic [3:0] key);
    put(1'b1, 1'b0, 8'h00, 8'h20, {key, 12'h000});
    put(1'b1, 1'b0, 8'h00, 8'h1f, 16'h0fff);
  endtask
endmodule

// ==== test/qdc_regs_bench.sv ====
// self-checking bench for the shared control bank
module qdc_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] sync_select = 4'h5;
  logic [3:0] clear_level_select = 4'h3;
  logic [10:0] seen = '0;
  int n_fail = 0;
  int n_compared = 0;
  wire wr_en, rd_en, pm_mode, rvalid, window_hold_select, register_freeze, dump_row_select;
  wire internal_ref_en, clear_outputs_strobe, fault_dump_strobe, protect_strobe;
  wire snapshot_row_read, nonvolatile_store_strobe, nonvolatile_restore_strobe;
  wire soft_reset_pulse;
  wire [7:0] pm_page, addr, voltage_out_powerdown;
  wire [15:0] wdata, rdata;
  wire [3:0] current_out_powerdown, load_outputs_strobe;
  qdc_regs u_qdc_regs (.clk, .rstn, .wr_en, .rd_en, .pm_mode, .pm_page, .addr, .wdata, .rdata,
    .rvalid, .sync_select, .clear_level_select, .window_hold_select, .register_freeze,
    .dump_row_select, .internal_ref_en, .voltage_out_powerdown, .current_out_powerdown,
    .load_outputs_strobe, .clear_outputs_strobe, .fault_dump_strobe, .protect_strobe,
    .snapshot_row_read, .nonvolatile_store_strobe, .nonvolatile_restore_strobe,
    .soft_reset_pulse);
  qdc_host u_qdc_host (.clk, .wr_en, .rd_en, .pm_mode, .pm_page, .addr, .wdata, .rvalid, .rdata);
  always #4 clk = ~clk;
  // strobes gathered between edges; a write being issued starts a fresh gather
  always @(negedge clk) seen <= wr_en ? 11'h000 : seen | {soft_reset_pulse, load_outputs_strobe,
    clear_outputs_strobe, fault_dump_strobe, protect_strobe, snapshot_row_read,
    nonvolatile_store_strobe, nonvolatile_restore_strobe};
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_qdc_host.get(1'b0, 8'h00, a, d);
    chk("read", d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_qdc_host.put(1'b1, 1'b0, 8'h00, a, d);
    @(negedge clk);
  endtask
  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  // reset values, and an unmapped place reading zero
  task automatic t_reset;
    rdc(8'h1f, 16'h0fff);
    rdc(8'h1c, 16'h0000);
    rdc(8'h1d, 16'h0000);
  endtask
  // low nibble dropped; paged view matches flat view
  task automatic t_codes;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) wr(8'h19 + i[7:0], 16'h123f + 16'h1111 * i[15:0]);
    for (int i = 0; i < 4; i++)
      rdc(8'h19 + i[7:0], (16'h123f + 16'h1111 * i[15:0]) & 16'hfff0);
    u_qdc_host.get(1'b1, 8'h02, 8'h21, d);
    chk("paged code", d, 16'h3460);
  endtask
  // paged config write reaches the field outputs
  task automatic t_config;
    logic [15:0] d;
    logic [15:0] e;
    logic [15:0] f;
    d = 16'hb5a6;
    e = {d[15:12], d[11:10], d[8:7], d[5:4], d[2:1], d[9], d[6], d[3], d[0]};
    u_qdc_host.put(1'b1, 1'b1, 8'hff, 8'he3, d);
    rdc(8'h1f, d);
    f = {window_hold_select, register_freeze, dump_row_select, internal_ref_en,
      voltage_out_powerdown, current_out_powerdown};
    chk("fields", f, e);
  endtask
  // each command bit alone, then the clear levels
  task automatic t_trig;
    logic [15:0] e;
    for (int k = 0; k < 7; k++)
    begin
      wr(8'h20, k < 5 ? 16'h1 << k : 16'h40 << (k - 5));
      e = k < 6 ? 16'h1 << k : {6'h0, sync_select, 6'h0};
      chk("strobes", 16'(seen), e);
    end
    for (int i = 0; i < 4; i++)
      rdc(8'h19 + i[7:0], clear_level_select[i] ? 16'h8000 : 16'h0000);
  endtask
  // soft reset restores the bank, codes included
  task automatic t_srst;
    wr(8'h20, 16'h0a00);
    chk("soft reset", 16'(seen), 16'h0400);
    rdc(8'h19, 16'h0000);
    rdc(8'h1f, 16'h0fff);
  endtask
  // frozen writes dropped; only the right key lets freeze clear
  task automatic t_lock;
    wr(8'h1f, 16'h4fff);
    chk("frozen", {15'h0, register_freeze}, 16'h1);
    wr(8'h19, 16'h1230);
    wr(8'h1f, 16'h4000);
    wr(8'h20, 16'h0001);
    chk("frozen cmd", 16'(seen), 16'h0);
    rdc(8'h19, 16'h0000);
    u_qdc_host.unlock(4'h3);
    rdc(8'h20, 16'h3000);
    chk("wrong key", {15'h0, register_freeze}, 16'h1);
    u_qdc_host.unlock(4'h5);
    @(negedge clk);
    chk("unlocked", {15'h0, register_freeze}, 16'h0);
  endtask
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_codes;
    t_config;
    t_trig;
    t_srst;
    t_lock;
    test_done;
  end
  // hang guard, over thirty times the expected run of about 1.24us
  initial
  begin
    #50us;
    n_fail++;
    test_done;
  end
endmodule
